// ---- common/sws_pkg.sv ----
package sws_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned FREQ_LOW_HZ = 44_000;
    localparam int unsigned FREQ_HIGH_HZ = 130_000;
    // period counts, rounded down
    localparam int unsigned PERIOD_LOW_CYC = CLK_HZ / FREQ_LOW_HZ;
    localparam int unsigned PERIOD_HIGH_CYC = CLK_HZ / FREQ_HIGH_HZ;
    // duty window in percent
    localparam int unsigned MAX_DUTY_PCT = 67;
    // turn-on blanking time in ns, plain default
    localparam int unsigned BLANK_NS = 200;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 10;

    typedef enum logic [1:0] {
        SWS_IDLE = 2'b00,
        SWS_ON = 2'b01,
        SWS_DONE = 2'b10
    } sws_state_t;
endpackage : sws_pkg

// ---- hw/sws_sync.sv ----
module sws_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    // two flops, first read only by second
    always_comb begin
        next_stage1 = ce ? din : stage1;
        next_dout = ce ? stage1 : dout;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule : sws_sync

// ---- hw/sws_switch_ctrl.sv ----
// Contract
// - gate on at enabled cycle start
// - gate off on current limit
// - gate off at duty window end
// - enable changes ignored mid cycle
// - oscillator runs continuously
// - sample enable once per cycle start
// - low sample skips whole cycle
// - period 44 kHz or 130 kHz
// - duty window 67 percent, start pulse
// - skipping doubles frequency, except high variant
// - blank current limit after turn-on
module sws_switch_ctrl
    import sws_pkg::*;
#(
    parameter bit HIGH_VARIANT = 1'b0,
    parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic fb_enable,
    input wire logic current_limit,
    output logic gate,
    output logic max_duty_window,
    output logic cycle_start,
    output logic skip_mode
);
    localparam int unsigned PER_NOM = HIGH_VARIANT ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
    localparam int unsigned PER_FAST = HIGH_VARIANT ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC / 2;

    // window lengths in clocks, nominal and fast
    localparam int unsigned DUTY_NOM = (PER_NOM * MAX_DUTY_PCT) / 100;
    localparam int unsigned DUTY_FAST = (PER_FAST * MAX_DUTY_PCT) / 100;

    // period must fit the phase counter
    if (PER_NOM >= (1 << CNT_W)) begin : g_bad_period
        $error("sws_switch_ctrl: period does not fit the phase counter");
    end

    // fast period needs room for a start pulse
    if (PER_FAST < 2) begin : g_bad_fast
        $error("sws_switch_ctrl: fast period too short");
    end

    // blanking must end inside the shortest window
    if (BLANK_CYCLES < 1 || BLANK_CYCLES >= DUTY_FAST) begin : g_bad_blank
        $error("sws_switch_ctrl: blanking out of range");
    end

    // window must leave an off time in every period
    if (DUTY_NOM >= PER_NOM || DUTY_FAST >= PER_FAST) begin : g_bad_duty
        $error("sws_switch_ctrl: duty window fills the period");
    end

    // window length for a given period
    function automatic logic [CNT_W-1:0] duty_len(input logic fast);
        int unsigned p;
        p = fast ? PER_FAST : PER_NOM;
        duty_len = CNT_W'((p * MAX_DUTY_PCT) / 100);
    endfunction : duty_len

    // period length in clocks for a given mode
    function automatic logic [CNT_W-1:0] period_len(input logic fast);
        period_len = fast ? CNT_W'(PER_FAST) : CNT_W'(PER_NOM);
    endfunction : period_len

    // synchronised feedback enable
    logic en_sync;

    // oscillator phase and next values
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] next_phase;
    logic next_window;
    logic next_start;
    logic next_skip;
    logic at_end;

    // blanking counter
    logic [CNT_W-1:0] blank;
    logic [CNT_W-1:0] next_blank;

    // switch state and gate
    sws_state_t state;
    sws_state_t next_state;
    logic next_gate;

    sws_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .din(fb_enable),
        .dout(en_sync)
    );

    always_comb begin
        // last phase of the present period
        at_end = (phase == period_len(skip_mode) - CNT_W'(1));
        // phase wraps to zero at period end
        if (at_end) begin
            next_phase = '0;
        end else begin
            next_phase = phase + CNT_W'(1);
        end
        // start pulse in first clock of a period
        next_start = at_end;
        next_skip = skip_mode;
        if (at_end) begin
            next_skip = ~en_sync;
        end
        next_window = next_phase < duty_len(next_skip);
    end

    // register oscillator state and outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
            max_duty_window <= 1'b0;
            cycle_start <= 1'b0;
            skip_mode <= 1'b0;
        end else if (ce) begin
            phase <= next_phase;
            max_duty_window <= next_window;
            cycle_start <= next_start;
            skip_mode <= next_skip;
        end
    end

    // blanking count, reloaded at every cycle start
    always_comb begin
        next_blank = blank;
        if (at_end) begin
            next_blank = CNT_W'(BLANK_CYCLES);
        end else if (state == SWS_ON && blank != '0) begin
            next_blank = blank - CNT_W'(1);
        end
    end

    // register blanking count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blank <= '0;
        end else if (ce) begin
            blank <= next_blank;
        end
    end

    // switch state per cycle
    always_comb begin
        next_state = state;
        next_gate = gate;
        if (at_end) begin
            next_state = en_sync ? SWS_ON : SWS_IDLE;
            next_gate = en_sync;
        end else begin
            case (state)
                SWS_ON: begin
                    if (blank == '0 && current_limit) begin
                        next_state = SWS_DONE;
                        next_gate = 1'b0;
                    end
                    if (!next_window) begin
                        next_state = SWS_DONE;
                        next_gate = 1'b0;
                    end
                end
                SWS_IDLE, SWS_DONE: begin
                    next_gate = 1'b0;
                end
                default: begin
                    next_state = SWS_IDLE;
                    next_gate = 1'b0;
                end
            endcase
        end
    end

    // register switch state and gate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SWS_IDLE;
            gate <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            gate <= next_gate;
        end
    end
endmodule : sws_switch_ctrl

// ---- verif/sws_chk.sv ----
module sws_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic current_limit,
    input wire logic gate,
    input wire logic max_duty_window,
    input wire logic cycle_start,
    input wire logic skip_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_gate_win: assert property (gate |-> max_duty_window)
        else $error("gate outside window");
    a_blank_hold: assert property ($rose(gate) |-> gate[*4])
        else $error("blanking cut short");
    a_limit_off: assert property ((gate && current_limit)[*6] |-> 1'b0)
        else $error("limit ignored");
    a_skip_off: assert property ($rose(skip_mode) |-> !gate)
        else $error("gate on in skip");
    a_no_mid_on: assert property (!gate && !cycle_start |=> !gate || cycle_start)
        else $error("gate on mid cycle");
    a_start_gate: assert property (cycle_start |-> gate == !skip_mode)
        else $error("gate vs sample");
    a_start_win: assert property (cycle_start |-> max_duty_window)
        else $error("window late");
    a_start_once: assert property (cycle_start |=> !cycle_start)
        else $error("start too long");
endmodule : sws_chk
bind sws_switch_ctrl sws_chk u_chk (.clk(clk), .rst_n(rst_n), .gate(gate),
    .cycle_start(cycle_start), .current_limit(current_limit),
    .max_duty_window(max_duty_window), .skip_mode(skip_mode));

// ---- verif/sws_fb_model.sv ----
module sws_fb_model (
    input wire logic clk,
    input wire logic cycle_start,
    input wire logic gate,
    input wire logic [2:0] load,
    output logic fb_enable = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    int v = 0;
    always @(negedge clk) if (cycle_start) begin
        v += (gate ? 4 : 0) - load;
        fb_enable <= v < 8;
    end
endmodule : sws_fb_model

// ---- verif/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, lim, fb, gate, win, cs, sk;
    logic [2:0] load;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    sws_switch_ctrl DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .fb_enable(fb),
        .current_limit(lim), .gate(gate), .max_duty_window(win), .cycle_start(cs),
        .skip_mode(sk));
    sws_fb_model u_fb (.clk(clk), .cycle_start(cs), .gate(gate), .load(load), .fb_enable(fb));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) if (++cyc == 9000) begin
        n_mismatch++;
        finish_test();
    end
    task automatic chk(string s, int e, int g);
        num_checks++;
        if (g != e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %0d got %0d", s, e, g);
        end
    endtask : chk
    // one period: gate-high cycles and length
    task automatic meas(int eh, int ep, int ew);
        int hi = 0;
        int per = 0;
        int wh = 0;
        @(negedge clk);
        while (cs !== 1'b1) @(negedge clk);
        do begin
            hi += int'(gate === 1'b1);
            wh += int'(win === 1'b1);
            per++;
            @(negedge clk);
        end while (cs !== 1'b1);
        chk("width", eh, hi);
        chk("period", ep, per);
        chk("window", ew, wh);
    endtask : meas
    task automatic t_full();
        meas(304, 454, 304);
        $display("full end");
    endtask : t_full
    task automatic t_limit();
        lim = 1'b1;
        meas(5, 454, 304);
        lim = 1'b0;
        $display("limit end");
    endtask : t_limit
    task automatic t_skip();
        load = 3'h0;
        repeat (3) @(posedge cs);
        meas(0, 227, 152);
        chk("skip", 1, int'(sk === 1'b1));
        $display("skip end");
    endtask : t_skip
    initial begin
        {rst_n, lim, load} = 5'h04;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_full();
        t_limit();
        t_skip();
        finish_test();
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
endmodule : tb
